// ===== logic/ascn_pkg.sv
// Constants, register map and carrier types of the autoscan sequencer
package ascn_pkg;
  localparam int unsigned ASCN_AW = 10;
  localparam logic [7:0] ASCN_IDX_SCFG = 8'ha1;
  localparam logic [7:0] ASCN_IDX_SAL = 8'hb5;
  localparam logic [7:0] ASCN_IDX_SAH = 8'hb6;
  localparam logic [7:0] ASCN_IDX_MUX = 8'hbb;
  localparam logic [7:0] ASCN_IDX_CNT = 8'hc7;
  localparam logic [7:0] ASCN_IDX_STAT = 8'he8;
  localparam int unsigned ASCN_EN_BIT = 7;
  localparam int unsigned ASCN_ST_BIT = 6;
  localparam int unsigned ASCN_ACT_BIT = 5;
  localparam int unsigned ASCN_END_BIT = 0;
  localparam int unsigned ASCN_FLAG_BIT = 0;
  localparam logic [4:0] ASCN_MUX_RST = 5'h1f;
  localparam logic [1:0] ASCN_RESP_OKAY = 2'h0;
  localparam logic [1:0] ASCN_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic start;
    logic [4:0] chan;
  } ascn_conv_t;

  typedef struct packed {
    logic done;
    logic [15:0] data;
  } ascn_res_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } ascn_mem_t;

  function automatic logic [7:0] ascn_idx(input logic [ASCN_AW-1:0] a);
    return a[ASCN_AW-1:2];
  endfunction

  function automatic logic ascn_hit(input logic [ASCN_AW-1:0] a);
    logic [7:0] i;
    i = a[ASCN_AW-1:2];
    return (a[1:0] == 2'h0) && (i == ASCN_IDX_SCFG || i == ASCN_IDX_SAL ||
      i == ASCN_IDX_SAH || i == ASCN_IDX_MUX || i == ASCN_IDX_CNT ||
      i == ASCN_IDX_STAT);
  endfunction
endpackage

// ===== logic/ascn_axil.sv
// AXI4-Lite slave front end of the autoscan registers
`timescale 1ns/10ps
`default_nettype none
module ascn_axil import ascn_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ASCN_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ASCN_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rd_byte,
  output logic wr_en,
  output logic [ASCN_AW-1:0] wr_addr,
  output logic [7:0] wr_byte
);
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, we_q, we_d;
  logic awr_q, awr_d, wrd_q, wrd_d, arr_q, arr_d;
  logic [ASCN_AW-1:0] a_q, a_d;
  logic [7:0] wb_q, wb_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    a_d = a_q;
    wb_d = wb_q;
    bv_d = bv_q;
    br_d = br_q;
    we_d = 1'b0;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_axi_awvalid && !aw_q && !bv_q) begin
      aw_d = 1'b1;
      a_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q) begin
      w_d = 1'b1;
      wb_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      we_d = 1'b0;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = ascn_hit(a_q) ? ASCN_RESP_OKAY : ASCN_RESP_SLVERR;
      we_d = ascn_hit(a_q);
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = ascn_hit(s_axi_araddr) ? ASCN_RESP_OKAY : ASCN_RESP_SLVERR;
      rd_d = ascn_hit(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    awr_d = !aw_d && !bv_d;
    wrd_d = !w_d && !bv_d;
    arr_d = !rv_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= '0;
      wb_q <= 8'h00;
      bv_q <= 1'b0;
      br_q <= ASCN_RESP_OKAY;
      we_q <= 1'b0;
      rv_q <= 1'b0;
      rr_q <= ASCN_RESP_OKAY;
      rd_q <= 32'h00000000;
      awr_q <= 1'b1;
      wrd_q <= 1'b1;
      arr_q <= 1'b1;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      a_q <= a_d;
      wb_q <= wb_d;
      bv_q <= bv_d;
      br_q <= br_d;
      we_q <= we_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      awr_q <= awr_d;
      wrd_q <= wrd_d;
      arr_q <= arr_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wrd_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;
  assign wr_en = we_q;
  assign wr_addr = a_q;
  assign wr_byte = wb_q;
endmodule // ascn_axil
`default_nettype wire

// ===== logic/ascn_store.sv
// Two-byte result writer into data memory
`timescale 1ns/10ps
`default_nettype none
module ascn_store import ascn_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [15:0] result,
  input wire logic [11:0] base,
  input wire logic little,
  output ascn_mem_t mem,
  output logic done
);
  logic ph_q, ph_d, dn_q, dn_d, lt_q, lt_d;
  logic [15:0] r_q, r_d;
  ascn_mem_t m_q, m_d;

  always_comb begin
    ph_d = 1'b0;
    dn_d = 1'b0;
    r_d = r_q;
    lt_d = lt_q;
    m_d = '0;
    if (go) begin
      ph_d = 1'b1;
      r_d = result;
      lt_d = little;
      m_d.we = 1'b1;
      m_d.addr = base;
      m_d.data = little ? result[7:0] : result[15:8];
    end else if (ph_q) begin
      dn_d = 1'b1;
      m_d.we = 1'b1;
      m_d.addr = m_q.addr + 12'h001;
      m_d.data = lt_q ? r_q[15:8] : r_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q <= 1'b0;
      dn_q <= 1'b0;
      r_q <= 16'h0000;
      lt_q <= 1'b0;
      m_q <= '0;
    end else begin
      ph_q <= ph_d;
      dn_q <= dn_d;
      r_q <= r_d;
      lt_q <= lt_d;
      m_q <= m_d;
    end
  end

  assign mem = m_q;
  assign done = dn_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_big_endian: assert property (
    go && !little |=> mem.data == $past(result[15:8])
    ##1 mem.data == $past(result[7:0], 2) && mem.addr[0])
    else $error("big-endian byte order wrong");
  a_little_endian: assert property (
    go && little |=> mem.data == $past(result[7:0])
    ##1 mem.data == $past(result[15:8], 2) && mem.addr[0])
    else $error("little-endian byte order wrong");
endmodule // ascn_store
`default_nettype wire

// ===== logic/ascn_seq.sv
// Autoscan sequencer top: registers, scan state machine, result storage
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ascn_seq import ascn_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ASCN_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ASCN_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_trigger,
  input wire ascn_res_t conv_res,
  output ascn_conv_t conv,
  output ascn_mem_t mem,
  output logic conversion_complete_flag,
  output logic scan_active_status
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CONV, S_STORE} ascn_state_t;

  logic wr_en;
  logic [ASCN_AW-1:0] wr_addr;
  logic [7:0] wr_byte, rd_byte, widx;
  logic st_done, scan_end;

  logic scan_enable_q, scan_enable_d, single_q, single_d, endian_q, endian_d;
  logic flag_q, flag_d;
  logic [1:0] chn_q, chn_d;
  logic [3:0] upper_q, upper_d;
  logic [6:0] lower_q, lower_d;
  logic [4:0] mux_q, mux_d;
  logic [5:0] cnt_q, cnt_d;

  ascn_state_t st_q, st_d;
  logic act_q, act_d, sh_single_q, sh_single_d, sh_end_q, sh_end_d;
  logic [1:0] sh_chn_q, sh_chn_d, ofs_q, ofs_d;
  logic [4:0] sh_base_q, sh_base_d;
  logic [5:0] left_q, left_d;
  logic [11:0] ptr_q, ptr_d;
  ascn_conv_t conv_q, conv_d;

  function automatic logic [4:0] chan_of(input logic [4:0] b, input logic [1:0] o);
    return b + {3'h0, o};
  endfunction

  ascn_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rd_byte(rd_byte),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_byte(wr_byte)
  );

  ascn_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(st_q == S_CONV && conv_res.done),
    .result(conv_res.data),
    .base(ptr_q),
    .little(sh_end_q),
    .mem(mem),
    .done(st_done)
  );

  // Register read mux
  always_comb begin
    rd_byte = 8'h00;
    case (ascn_idx(s_axi_araddr))
      ASCN_IDX_SCFG: begin
        rd_byte[ASCN_EN_BIT] = scan_enable_q;
        rd_byte[ASCN_ST_BIT] = single_q;
        rd_byte[ASCN_ACT_BIT] = act_q;
        rd_byte[1:0] = chn_q;
      end
      ASCN_IDX_SAL: rd_byte = {lower_q, endian_q};
      ASCN_IDX_SAH: rd_byte = {4'h0, upper_q};
      ASCN_IDX_MUX: rd_byte = {3'h0, mux_q};
      ASCN_IDX_CNT: rd_byte = {2'h0, cnt_q};
      ASCN_IDX_STAT: rd_byte[ASCN_FLAG_BIT] = flag_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Register writes; hardware set of the flag wins over clear
  always_comb begin
    widx = ascn_idx(wr_addr);
    scan_enable_d = scan_enable_q;
    single_d = single_q;
    chn_d = chn_q;
    upper_d = upper_q;
    lower_d = lower_q;
    endian_d = endian_q;
    mux_d = mux_q;
    cnt_d = cnt_q;
    flag_d = flag_q;
    if (wr_en) begin
      case (widx)
        ASCN_IDX_SCFG: begin
          scan_enable_d = wr_byte[ASCN_EN_BIT];
          single_d = wr_byte[ASCN_ST_BIT];
          chn_d = wr_byte[1:0];
        end
        ASCN_IDX_SAL: begin
          lower_d = wr_byte[7:1];
          endian_d = wr_byte[ASCN_END_BIT];
        end
        ASCN_IDX_SAH: upper_d = wr_byte[3:0];
        ASCN_IDX_MUX: mux_d = wr_byte[4:0];
        ASCN_IDX_CNT: cnt_d = wr_byte[5:0];
        ASCN_IDX_STAT: begin
          if (wr_byte[ASCN_FLAG_BIT]) begin
            flag_d = 1'b0;
          end
        end
        default: flag_d = flag_q;
      endcase
    end
    if (scan_end) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_enable_q <= 1'b0;
      single_q <= 1'b0;
      chn_q <= 2'h0;
      upper_q <= 4'h0;
      lower_q <= 7'h00;
      endian_q <= 1'b0;
      mux_q <= ASCN_MUX_RST;
      cnt_q <= 6'h00;
      flag_q <= 1'b0;
    end else begin
      scan_enable_q <= scan_enable_d;
      single_q <= single_d;
      chn_q <= chn_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
      endian_q <= endian_d;
      mux_q <= mux_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
    end
  end

  // Scan state machine
  always_comb begin
    st_d = st_q;
    act_d = act_q;
    sh_single_d = sh_single_q;
    sh_end_d = sh_end_q;
    sh_chn_d = sh_chn_q;
    sh_base_d = sh_base_q;
    left_d = left_q;
    ptr_d = ptr_q;
    ofs_d = ofs_q;
    conv_d = conv_q;
    conv_d.start = 1'b0;
    scan_end = 1'b0;
    case (st_q)
      S_IDLE: begin
        sh_base_d = mux_q;
        ofs_d = 2'h0;
      end
      S_WAIT: begin
        if (conv_trigger) begin
          conv_d.start = 1'b1;
          st_d = S_CONV;
        end
      end
      S_CONV: begin
        if (conv_res.done) begin
          st_d = S_STORE;
        end
      end
      S_STORE: begin
        if (st_done) begin
          if (left_q == 6'h00) begin
            scan_end = 1'b1;
            st_d = S_IDLE;
            act_d = 1'b0;
          end else begin
            left_d = left_q - 6'h01;
            ptr_d = ptr_q + 12'h002;
            ofs_d = (ofs_q == sh_chn_q) ? 2'h0 : ofs_q + 2'h1;
            if (sh_single_q) begin
              conv_d.start = 1'b1;
              st_d = S_CONV;
            end else begin
              st_d = S_WAIT;
            end
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (scan_enable_q && (st_q == S_IDLE || scan_end)) begin
      st_d = S_WAIT;
      act_d = 1'b1;
      sh_single_d = single_q;
      sh_end_d = endian_q;
      sh_chn_d = chn_q;
      sh_base_d = mux_q;
      left_d = cnt_q;
      ptr_d = {upper_q, lower_q, 1'b0};
      ofs_d = 2'h0;
    end
    conv_d.chan = chan_of(sh_base_d, ofs_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      act_q <= 1'b0;
      sh_single_q <= 1'b0;
      sh_end_q <= 1'b0;
      sh_chn_q <= 2'h0;
      sh_base_q <= ASCN_MUX_RST;
      left_q <= 6'h00;
      ptr_q <= 12'h000;
      ofs_q <= 2'h0;
      conv_q <= '{start: 1'b0, chan: ASCN_MUX_RST};
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      sh_single_q <= sh_single_d;
      sh_end_q <= sh_end_d;
      sh_chn_q <= sh_chn_d;
      sh_base_q <= sh_base_d;
      left_q <= left_d;
      ptr_q <= ptr_d;
      ofs_q <= ofs_d;
      conv_q <= conv_d;
    end
  end

  assign conv = conv_q;
  assign conversion_complete_flag = flag_q;
  assign scan_active_status = act_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence scan_launch;
    scan_enable_q && (st_q == S_IDLE || scan_end);
  endsequence

  a_trig_per_conv: assert property (conv_q.start && !sh_single_q |-> $past(conv_trigger))
    else $error("conversion started without trigger");
  a_auto_next: assert property (
    st_q == S_STORE && st_done && sh_single_q && left_q != 6'h00 |=> conv_q.start)
    else $error("single-trigger scan did not chain");
  a_flag_at_end: assert property (
    $rose(flag_q) |-> $past(st_done) && $past(left_q) == 6'h00)
    else $error("flag set outside scan end");
  a_base_only: assert property (
    conv_q.start && sh_chn_q == 2'h0 |-> conv_q.chan == sh_base_q)
    else $error("stepped with zero channel count");
  a_chan_window: assert property (
    conv_q.start |-> 5'(conv_q.chan - sh_base_q) <= {3'h0, sh_chn_q})
    else $error("channel outside scan window");
  a_ptr_start: assert property (
    scan_launch |=> ptr_q == {$past(upper_q), $past(lower_q), 1'b0}
    && sh_chn_q == $past(chn_q))
    else $error("scan did not latch settings");
  a_halt_idle: assert property (st_q == S_IDLE && !scan_enable_q |=> st_q == S_IDLE)
    else $error("scan started while disabled");
  a_ptr_step: assert property (
    st_q == S_STORE && st_done && left_q != 6'h00
    |=> ptr_q == $past(ptr_q) + 12'h002 && left_q == $past(left_q) - 6'h01)
    else $error("pointer or count did not step");
endmodule // ascn_seq
`default_nettype wire

// ===== bench/ascn_partner.sv
// Converter and data memory stand-in facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module ascn_partner import ascn_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire ascn_conv_t conv,
  input wire ascn_mem_t mem,
  output ascn_res_t conv_res
);
  logic [7:0] ram [0:4095];
  logic [4:0] chan_q;
  logic [7:0] wait_q;
  logic done_q;
  logic [15:0] noise_q = 16'h1234;
  always @(posedge aclk) begin
    noise_q <= noise_q + 16'h9e37;
    done_q <= 1'b0;
    if (mem.we) begin
      ram[mem.addr] <= mem.data;
    end
    if (!aresetn) begin
      wait_q <= 8'h00;
    end else if (conv.start) begin
      chan_q <= conv.chan;
      wait_q <= slow ? 8'h0c : 8'h01;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
      done_q <= (wait_q == 8'h01);
    end
  end
  // Result ties to the channel; data moves when not valid
  assign conv_res = '{done: done_q, data: done_q ? {chan_q, 3'h5, ~chan_q, 3'h2} : noise_q};
endmodule // ascn_partner
`default_nettype wire

// ===== bench/ascn_seq_tb.sv
// Self-checking bench of the autoscan sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module ascn_seq_tb import ascn_pkg::*; ();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h0;
  logic [9:0] araddr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flag, active;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic conv_trigger = 1'b0;
  logic slow = 1'b1;
  ascn_res_t conv_res;
  ascn_conv_t conv;
  ascn_mem_t mem;
  int miscompares = 0;
  int checked = 0;
  int starts = 0;
  logic [19:0] exp_q[$];
  logic [19:0] nxt;
  logic [4:0] b;
  logic [1:0] n;
  logic [5:0] k;
  logic [11:0] ad;

  ascn_seq u_ascn_seq (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_trigger(conv_trigger), .conv_res(conv_res),
    .conv(conv), .mem(mem), .conversion_complete_flag(flag),
    .scan_active_status(active));
  ascn_partner u_ascn_partner (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .conv(conv), .mem(mem), .conv_res(conv_res));

  initial begin
    forever #25 aclk = ~aclk;
  end

  // Each stored byte against the oldest expectation
  always @(posedge aclk) begin
    if (conv.start) starts++;
    if (aresetn && mem.we) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        nxt = exp_q.pop_front();
        `CHK({mem.addr, mem.data}, nxt)
      end
    end
  end

  task automatic end_of_test();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail();
    $display("mismatch %0t wait ran out", $time);
    miscompares++;
    end_of_test();
  endtask

  task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        `CHK(bresp, er)
        return;
      end
    end
    fail();
  endtask

  task automatic axi_rd(input logic [9:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        return;
      end
    end
    fail();
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
    axi_rd(a);
    `CHK({rs, rd}, {ASCN_RESP_OKAY, e})
  endtask

  task automatic trig();
    @(posedge aclk);
    conv_trigger <= 1'b1;
    @(posedge aclk);
    conv_trigger <= 1'b0;
  endtask

  task automatic setup(input logic [4:0] sb, input logic [5:0] sk, input logic [11:0] sa,
      input logic le);
    axi_wr(10'h2ec, {3'h0, sb}, ASCN_RESP_OKAY);
    axi_wr(10'h31c, {2'h0, sk}, ASCN_RESP_OKAY);
    axi_wr(10'h2d4, {sa[7:1], le}, ASCN_RESP_OKAY);
    axi_wr(10'h2d8, {4'h0, sa[11:8]}, ASCN_RESP_OKAY);
    axi_wr(10'h3a0, 8'h01, ASCN_RESP_OKAY);
  endtask

  // Expected byte writes of one whole scan
  task automatic push_scan(input logic [4:0] sb, input logic [1:0] sn, input logic [5:0] sk,
      input logic [11:0] sa, input logic le);
    logic [4:0] c;
    logic [15:0] v;
    logic [11:0] p;
    for (int i = 0; i <= int'(sk); i++) begin
      c = sb + 5'(i % (int'(sn) + 1));
      v = {c, 3'h5, ~c, 3'h2};
      p = sa + 12'(2 * i);
      exp_q.push_back({p, le ? v[7:0] : v[15:8]});
      exp_q.push_back({p + 12'h1, le ? v[15:8] : v[7:0]});
    end
  endtask

  task automatic wait_left(input int left, input logic fchk);
    for (int i = 0; i < 3000; i++) begin
      @(negedge aclk);
      if (fchk && exp_q.size() > 0) `CHK(flag, 1'b0)
      if (exp_q.size() <= left && (left != 0 || active !== 1'b1)) return;
    end
    fail();
  endtask

  initial begin
    void'($urandom(32'h22eb2200));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, read-only bits, field widths, unmapped places
    rd_chk(10'h284, 32'h0);
    rd_chk(10'h2d4, 32'h0);
    rd_chk(10'h2d8, 32'h0);
    rd_chk(10'h2ec, 32'h1f);
    rd_chk(10'h31c, 32'h0);
    axi_rd(10'h000);
    `CHK({rs, rd}, {ASCN_RESP_SLVERR, 32'h0})
    axi_wr(10'h004, 8'h55, ASCN_RESP_SLVERR);
    axi_wr(10'h284, 8'h23, ASCN_RESP_OKAY);
    rd_chk(10'h284, 32'h03);
    axi_wr(10'h2d8, 8'hff, ASCN_RESP_OKAY);
    rd_chk(10'h2d8, 32'h0f);
    axi_wr(10'h2ec, 8'hff, ASCN_RESP_OKAY);
    rd_chk(10'h2ec, 32'h1f);
    axi_wr(10'h31c, 8'hff, ASCN_RESP_OKAY);
    rd_chk(10'h31c, 32'h3f);
    // Single-trigger scans: count zero, random, wrapping with the longest run
    for (int e = 0; e < 3; e++) begin
      b = (e == 2) ? 5'h1e : 5'($urandom);
      n = (e == 0) ? 2'h0 : ((e == 2) ? 2'h3 : 2'($urandom));
      k = (e == 1) ? 6'h0 : ((e == 2) ? 6'h3f : 6'($urandom_range(7, 1)));
      ad = 12'($urandom) & 12'hffe;
      setup(b, k, ad, e[0]);
      push_scan(b, n, k, ad, e[0]);
      axi_wr(10'h284, {6'h30, n}, ASCN_RESP_OKAY);
      repeat (3) @(posedge aclk);
      trig();
      axi_wr(10'h284, {6'h10, n}, ASCN_RESP_OKAY);
      wait_left(0, 1'b1);
      `CHK(flag, 1'b1)
      rd_chk(10'h3a0, 32'h1);
    end
    // One trigger per conversion, fast converter
    slow <= 1'b0;
    setup(5'h03, 6'h02, 12'h100, 1'b0);
    push_scan(5'h03, 2'h1, 6'h02, 12'h100, 1'b0);
    axi_wr(10'h284, 8'h81, ASCN_RESP_OKAY);
    repeat (3) @(posedge aclk);
    starts = 0;
    for (int i = 0; i < 3; i++) begin
      trig();
      wait_left(4 - 2 * i, 1'b1);
      repeat (10) @(posedge aclk);
      `CHK(starts, i + 1)
      if (i == 1) axi_wr(10'h284, 8'h01, ASCN_RESP_OKAY);
    end
    // Settings changed mid-scan apply to the next scan only
    slow <= 1'b1;
    setup(5'h08, 6'h03, 12'h3f0, 1'b1);
    push_scan(5'h08, 2'h2, 6'h03, 12'h3f0, 1'b1);
    push_scan(5'h08, 2'h1, 6'h01, 12'h52c, 1'b0);
    axi_wr(10'h284, 8'hc2, ASCN_RESP_OKAY);
    repeat (3) @(posedge aclk);
    trig();
    axi_wr(10'h31c, 8'h01, ASCN_RESP_OKAY);
    axi_wr(10'h2d4, 8'h2c, ASCN_RESP_OKAY);
    axi_wr(10'h2d8, 8'h05, ASCN_RESP_OKAY);
    axi_wr(10'h284, 8'hc1, ASCN_RESP_OKAY);
    rd_chk(10'h284, 32'he1);
    wait_left(4, 1'b0);
    trig();
    axi_wr(10'h284, 8'h41, ASCN_RESP_OKAY);
    wait_left(0, 1'b0);
    trig();
    repeat (40) @(posedge aclk);
    `CHK(active, 1'b0)
    end_of_test();
  end
endmodule // ascn_seq_tb
`default_nettype wire
